// *** rtcss_pkg.sv ***
// Package: register map and field layout of the subsecond alarm and pin override block
package rtcss_pkg;
  localparam logic [7:0] RTCSS_PINCFG_OFS = 8'h40; // Tamper and backup pin config
  localparam logic [7:0] RTCSS_ALRMSS_OFS = 8'h44; // Alarm A subsecond match
  localparam logic [7:0] RTCSS_STAT_OFS = 8'h48; // Sticky event status, read only
  localparam logic [7:0] RTCSS_CLR_OFS = 8'h4C; // Event clear, write only
  localparam logic [7:0] RTCSS_IEN_OFS = 8'h50; // Event interrupt enable
  localparam logic [7:0] RTCSS_KEY_OFS = 8'h54; // Write protection key
  localparam int RTCSS_ALR_TYPE_BIT = 18; // Alarm pin type or value
  localparam int RTCSS_ALR_FEN_BIT = 19; // Alarm pin force enable
  localparam int RTCSS_OIN_VAL_BIT = 20; // Osc in pin value
  localparam int RTCSS_OIN_FEN_BIT = 21; // Osc in pin force enable
  localparam int RTCSS_OOUT_VAL_BIT = 22; // Osc out pin value
  localparam int RTCSS_OOUT_FEN_BIT = 23; // Osc out pin force enable
  localparam int RTCSS_SSVAL_LSB = 0; // Subsecond match value
  localparam int RTCSS_SSVAL_W = 15;
  localparam int RTCSS_SSMASK_LSB = 24; // Subsecond mask select
  localparam int RTCSS_SSMASK_W = 4;
  localparam int RTCSS_EV_MATCH = 0; // Subsecond alarm match event
  localparam int RTCSS_EV_REFUSED = 1; // Alarm write refused event
  localparam int RTCSS_EV_W = 2;
  localparam int RTCSS_STAT_UNLOCK_BIT = 8; // Status view of unlock state
  localparam logic [7:0] RTCSS_KEY1 = 8'hCA; // First unlock key
  localparam logic [7:0] RTCSS_KEY2 = 8'h53; // Second unlock key
  localparam logic [5:0] RTCSS_PINCFG_RST = 6'h00; // Pin fields at power-on
  localparam logic [14:0] RTCSS_SSVAL_RST = 15'h0000; // Subsecond at power-on
  localparam logic [3:0] RTCSS_SSMASK_RST = 4'h0; // Mask select at power-on
  typedef enum logic [1:0] {
    RTCSS_LOCKED,
    RTCSS_HALF,
    RTCSS_OPEN
  } rtcss_wp_t;
endpackage

// *** rtcss_top.sv ***
// Subsecond alarm A compare, pin override and their register slave
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Alarm output: type bit picks drain or push-pull
// - Forced alarm pin driven with type bit level
// - Alarm output and force off: port logic owns pin
// - Osc off, force on: osc-in driven value
// - Osc-in force off: port logic owns pin
// - Osc-out force off: port logic owns pin
// - Alarm writes only when disabled or initialising
// - Alarm writes need write protection unlocked
// - Power-on reset clears alarm register
// - Compare low bits with synchronous counter
// - Mask zero: alarm on each second step
// - Mask 1..14 compares lowest n bits
// - Mask fifteen compares all fifteen bits
// - Counter overflow bit never compared
module rtcss_top (
  input wire logic ref_clk_i, // Kernel clock, 50 MHz
  input wire logic rst_i, // Power-on reset, async, high
  input wire logic [7:0] avs_address_i, // Byte address
  input wire logic avs_read_i, // Read request
  input wire logic avs_write_i, // Write request
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Byte lanes
  output logic [31:0] avs_readdata_o, // Read data
  output logic avs_waitrequest_o, // Stall, high until answered
  input wire logic alarm_a_enable_i, // Alarm A enabled
  input wire logic init_mode_i, // Calendar in init mode
  input wire logic osc_enable_i, // Low speed ext osc on
  input wire logic alarm_out_req_i, // Pin carries alarm output
  input wire logic alarm_out_level_i, // Alarm output level
  input wire logic [15:0] sync_prescaler_i, // Sync counter, bit 15 overflow
  input wire logic second_tick_i, // Seconds count stepped
  output logic ss_match_o, // Subsecond match pulse
  output logic irq_o, // Level interrupt
  output logic alarm_pin_out_o, // Alarm pin level
  output logic alarm_pin_oe_n_o, // Alarm pin drive, low drives
  output logic alarm_pin_own_o, // Block owns alarm pin
  output logic osc_in_pin_out_o, // Osc in pin level
  output logic osc_in_pin_oe_n_o, // Osc in pin drive, low drives
  output logic osc_in_pin_own_o, // Block owns osc in pin
  output logic osc_out_pin_out_o, // Osc out pin level
  output logic osc_out_pin_oe_n_o, // Osc out pin drive, low drives
  output logic osc_out_pin_own_o // Block owns osc out pin
);
  import rtcss_pkg::*;

  // Bits taking part in the compare for a mask select code
  function automatic logic [14:0] cmp_mask(input logic [3:0] sel);
    logic [14:0] m;
    m = 15'h0000;
    for (int i = 0; i < RTCSS_SSVAL_W; i++) begin
      if (i < int'(sel)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  // Write completing at one register offset on the lane that holds its field
  function automatic logic wr_hit(input logic go, input logic [7:0] adr,
                                  input logic [7:0] ofs, input logic lane);
    return go && (adr == ofs) && lane;
  endfunction

  logic wait_r; // Waitrequest flop
  logic [31:0] rdata_r; // Read data flop
  logic [5:0] pincfg_r; // Pin fields, bits 23:18
  logic [14:0] ssval_r; // Subsecond match value
  logic [3:0] ssmask_r; // Mask select
  logic [1:0] stat_r; // Sticky events
  logic [1:0] ien_r; // Event enables
  rtcss_wp_t wp_r; // Protection state
  logic match_r; // Previous compare result
  logic ss_match_r; // Match pulse flop
  logic irq_r; // Interrupt flop
  logic alr_out_r, alr_oe_n_r, alr_own_r; // Alarm pin flops
  logic oin_out_r, oin_oe_n_r, oin_own_r; // Osc in flops
  logic oout_out_r, oout_oe_n_r, oout_own_r; // Osc out flops

  // Bus access completes on the edge where waitrequest is low
  logic wr_go, rd_go, ss_wr, ss_ok, match_now, ev_refused;
  logic [1:0] ev_set, ev_clr;
  logic [14:0] diff;
  assign wr_go = avs_write_i & ~wait_r;
  assign rd_go = avs_read_i & wait_r;
  assign ss_wr = wr_hit(wr_go, avs_address_i, RTCSS_ALRMSS_OFS, 1'b1);
  // Writable only unlocked and with alarm idle or in init
  assign ss_ok = (wp_r == RTCSS_OPEN) && (!alarm_a_enable_i || init_mode_i);
  assign ev_refused = ss_wr & ~ss_ok;
  // Only low 15 bits of counter enter the compare
  // A shift can leave bit 15 set; it must never block the alarm
  assign diff = sync_prescaler_i[14:0] ^ ssval_r;
  assign match_now = ((diff & cmp_mask(ssmask_r)) == 15'h0000);

  // One wait cycle per access keeps timing fixed
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~((avs_read_i | avs_write_i) & wait_r);
    end
  end

  // Read mux, loaded in the wait cycle so data stand at completion
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_go) begin
      rdata_r <= 32'h0000_0000;
      unique case (avs_address_i)
        RTCSS_PINCFG_OFS: begin
          rdata_r[RTCSS_OOUT_FEN_BIT:RTCSS_ALR_TYPE_BIT] <= pincfg_r;
        end
        RTCSS_ALRMSS_OFS: begin
          rdata_r[RTCSS_SSVAL_LSB +: RTCSS_SSVAL_W] <= ssval_r;
          rdata_r[RTCSS_SSMASK_LSB +: RTCSS_SSMASK_W] <= ssmask_r;
        end
        RTCSS_STAT_OFS: begin
          rdata_r[RTCSS_EV_W-1:0] <= stat_r;
          rdata_r[RTCSS_STAT_UNLOCK_BIT] <= (wp_r == RTCSS_OPEN);
        end
        RTCSS_IEN_OFS: begin
          rdata_r[RTCSS_EV_W-1:0] <= ien_r;
        end
        default: begin
          // Unmapped and write-only read as zero
          rdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Pin override fields, lane 2
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pincfg_r <= RTCSS_PINCFG_RST;
    end else if (wr_hit(wr_go, avs_address_i, RTCSS_PINCFG_OFS, avs_byteenable_i[2])) begin
      pincfg_r <= avs_writedata_i[RTCSS_OOUT_FEN_BIT:RTCSS_ALR_TYPE_BIT];
    end
  end

  // Alarm subsecond register; only power-on reset clears it
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ssval_r <= RTCSS_SSVAL_RST;
      ssmask_r <= RTCSS_SSMASK_RST;
    end else if (ss_wr && ss_ok) begin
      // Lanes 0 and 1 hold the match value, lane 3 the mask select
      if (avs_byteenable_i[0]) begin
        ssval_r[7:0] <= avs_writedata_i[7:0];
      end
      if (avs_byteenable_i[1]) begin
        ssval_r[14:8] <= avs_writedata_i[14:8];
      end
      if (avs_byteenable_i[3]) begin
        ssmask_r <= avs_writedata_i[RTCSS_SSMASK_LSB +: RTCSS_SSMASK_W];
      end
    end
  end

  // Two-key unlock; any other key write relocks
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_r <= RTCSS_LOCKED;
    end else if (wr_hit(wr_go, avs_address_i, RTCSS_KEY_OFS, avs_byteenable_i[0])) begin
      unique case (wp_r)
        RTCSS_LOCKED: begin
          wp_r <= (avs_writedata_i[7:0] == RTCSS_KEY1) ? RTCSS_HALF : RTCSS_LOCKED;
        end
        RTCSS_HALF: begin
          wp_r <= (avs_writedata_i[7:0] == RTCSS_KEY2) ? RTCSS_OPEN : RTCSS_LOCKED;
        end
        RTCSS_OPEN: begin
          wp_r <= RTCSS_LOCKED;
        end
        default: begin
          wp_r <= RTCSS_LOCKED;
        end
      endcase
    end
  end

  // Match pulse on compare rising, or each second step at mask zero
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      match_r <= 1'b0;
      ss_match_r <= 1'b0;
    end else begin
      match_r <= match_now;
      if (ssmask_r == 4'h0) begin
        ss_match_r <= second_tick_i;
      end else begin
        ss_match_r <= match_now & ~match_r;
      end
    end
  end

  // Sticky events; a set in the clear cycle wins
  assign ev_set = {ev_refused, ss_match_r};
  assign ev_clr = wr_hit(wr_go, avs_address_i, RTCSS_CLR_OFS, avs_byteenable_i[0]) ?
                  avs_writedata_i[1:0] : 2'b00;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_r <= 2'b00;
    end else begin
      stat_r <= (stat_r & ~ev_clr) | ev_set;
    end
  end

  // Interrupt enables
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ien_r <= 2'b00;
    end else if (wr_hit(wr_go, avs_address_i, RTCSS_IEN_OFS, avs_byteenable_i[0])) begin
      ien_r <= avs_writedata_i[1:0];
    end
  end

  // Interrupt follows enabled status one cycle late
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & ien_r);
    end
  end

  // Alarm pin: alarm output first, then force, else port logic
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      alr_out_r <= 1'b0;
      alr_oe_n_r <= 1'b1;
      alr_own_r <= 1'b0;
    end else if (alarm_out_req_i) begin
      alr_own_r <= 1'b1;
      if (pincfg_r[0]) begin
        alr_out_r <= alarm_out_level_i;
        alr_oe_n_r <= 1'b0;
      end else begin
        // Open drain: pull low only, release for high
        alr_out_r <= 1'b0;
        alr_oe_n_r <= alarm_out_level_i;
      end
    end else if (pincfg_r[1]) begin
      alr_own_r <= 1'b1;
      alr_out_r <= pincfg_r[0];
      alr_oe_n_r <= 1'b0;
    end else begin
      alr_own_r <= 1'b0;
      alr_out_r <= 1'b0;
      alr_oe_n_r <= 1'b1;
    end
  end

  // Osc in pin forced only while the oscillator is off
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      oin_out_r <= 1'b0;
      oin_oe_n_r <= 1'b1;
      oin_own_r <= 1'b0;
    end else begin
      oin_own_r <= ~osc_enable_i & pincfg_r[3];
      oin_oe_n_r <= ~(~osc_enable_i & pincfg_r[3]);
      oin_out_r <= ~osc_enable_i & pincfg_r[3] & pincfg_r[2];
    end
  end

  // Osc out pin, same scheme as osc in
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      oout_out_r <= 1'b0;
      oout_oe_n_r <= 1'b1;
      oout_own_r <= 1'b0;
    end else begin
      oout_own_r <= ~osc_enable_i & pincfg_r[5];
      oout_oe_n_r <= ~(~osc_enable_i & pincfg_r[5]);
      oout_out_r <= ~osc_enable_i & pincfg_r[5] & pincfg_r[4];
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;
  assign ss_match_o = ss_match_r;
  assign irq_o = irq_r;
  assign alarm_pin_out_o = alr_out_r;
  assign alarm_pin_oe_n_o = alr_oe_n_r;
  assign alarm_pin_own_o = alr_own_r;
  assign osc_in_pin_out_o = oin_out_r;
  assign osc_in_pin_oe_n_o = oin_oe_n_r;
  assign osc_in_pin_own_o = oin_own_r;
  assign osc_out_pin_out_o = oout_out_r;
  assign osc_out_pin_oe_n_o = oout_oe_n_r;
  assign osc_out_pin_own_o = oout_own_r;

  // Checks on the block's own outputs
  chk_write_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ss_wr && alarm_a_enable_i && !init_mode_i) |=> $stable(ssval_r) && $stable(ssmask_r))
    else $error("alarm register changed while alarm enabled");
  chk_wp_locked: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ss_wr && wp_r != RTCSS_OPEN) |=> $stable(ssval_r) && stat_r[RTCSS_EV_REFUSED])
    else $error("locked alarm write not refused");
  chk_mask_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ssmask_r == 4'h0) |=> (ss_match_r == $past(second_tick_i)))
    else $error("mask zero match not on second step");
  chk_match_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ss_match_r && $past(ssmask_r) != 4'h0) |->
      ((($past(sync_prescaler_i[14:0]) ^ $past(ssval_r)) & cmp_mask($past(ssmask_r))) == 15'h0)
      && !$past(match_r))
    else $error("match pulse without low bit match");
  chk_full_mask: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ssmask_r == 4'hF && sync_prescaler_i[14:0] != ssval_r) |=> !match_r)
    else $error("full mask matched on unequal value");
  chk_bit15_ignored: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ssmask_r != 4'h0 && sync_prescaler_i[14:0] == ssval_r && !match_r) |=> ss_match_r)
    else $error("overflow bit blocked the match");
  chk_alarm_drain: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (alarm_out_req_i && !pincfg_r[0]) |=> (alr_oe_n_r || !alr_out_r) && alr_own_r)
    else $error("open drain alarm drove high");
  chk_alarm_force: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!alarm_out_req_i && pincfg_r[1]) |=> !alr_oe_n_r && alr_out_r == $past(pincfg_r[0]))
    else $error("forced alarm pin level wrong");
  chk_alarm_free: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!alarm_out_req_i && !pincfg_r[1]) |=> alr_oe_n_r && !alr_own_r)
    else $error("alarm pin not released");
  chk_osc_in_pin: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!osc_enable_i && pincfg_r[3]) |=> !oin_oe_n_r && oin_out_r == $past(pincfg_r[2]))
    else $error("osc in pin not forced");
  chk_osc_in_free: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !pincfg_r[3] |=> oin_oe_n_r && !oin_own_r)
    else $error("osc in pin not released");
  chk_osc_out_pin: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!osc_enable_i && pincfg_r[5]) |=> !oout_oe_n_r && oout_out_r == $past(pincfg_r[4]))
    else $error("osc out pin not forced");
  chk_osc_out_free: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (osc_enable_i || !pincfg_r[5]) |=> oout_oe_n_r && !oout_own_r)
    else $error("osc out pin not released");

  // Bus handshake: exactly one wait cycle, then stalled again
  chk_bus_answer: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((avs_read_i || avs_write_i) && wait_r) |=> !wait_r)
    else $error("waitrequest not lowered after request");
  chk_bus_single: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !wait_r |=> wait_r)
    else $error("waitrequest low for more than one cycle");
  // Accepted writes with all four lanes enabled land whole; refused ones leave an event behind
  chk_accept_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ss_wr && ss_ok && avs_byteenable_i == 4'hF) |=>
      (ssval_r == $past(avs_writedata_i[RTCSS_SSVAL_LSB +: RTCSS_SSVAL_W]))
      && (ssmask_r == $past(avs_writedata_i[RTCSS_SSMASK_LSB +: RTCSS_SSMASK_W])))
    else $error("accepted alarm write not stored");
  chk_refused_event: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ss_wr && !ss_ok) |=> stat_r[RTCSS_EV_REFUSED])
    else $error("refused alarm write left no event");
  // Low bit compare by shifting the unused bits out, not by the mask table
  chk_low_bits: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ssmask_r != 4'h0 && !match_r &&
      15'((sync_prescaler_i[14:0] ^ ssval_r) << (4'hF - ssmask_r)) == 15'h0000) |=> ss_match_r)
    else $error("masked low bit match gave no pulse");
  // Sticky status and the level interrupt behind it
  chk_sticky_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (stat_r[RTCSS_EV_MATCH] && !ev_clr[RTCSS_EV_MATCH]) |=> stat_r[RTCSS_EV_MATCH])
    else $error("match status lost without a clear");
  chk_irq_level: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (|(stat_r & ien_r)) |=> irq_r)
    else $error("interrupt low with an enabled event");
  // Pin drive while the alarm or the oscillator owns the pin
  chk_alarm_push: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (alarm_out_req_i && pincfg_r[0]) |=> !alr_oe_n_r && alr_out_r == $past(alarm_out_level_i))
    else $error("push pull alarm level wrong");
  chk_osc_in_on: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    osc_enable_i |=> oin_oe_n_r && !oin_own_r)
    else $error("osc in pin driven while oscillator on");
endmodule // rtcss_top
`default_nettype wire

// *** rtcss_top_tb.sv ***
// Self-checking bench for the subsecond alarm and pin override block
`timescale 1ns/10ps
`default_nettype none
module rtcss_top_tb;
  import rtcss_pkg::*;
  logic ref_clk_i = 1'b0; // 50 MHz kernel clock
  logic rst_i = 1'b1; // Power-on reset
  logic [7:0] adr = 8'h00; // Bus address
  logic rd_req = 1'b0; // Bus read
  logic wr_req = 1'b0; // Bus write
  logic [31:0] wdat = 32'h0; // Bus write data
  logic [31:0] rdat; // Bus read data
  logic wait_req; // Bus stall
  logic alm_en = 1'b0; // Alarm A enable
  logic init_md = 1'b0; // Calendar init mode
  logic osc_en = 1'b1; // Low speed osc on
  logic out_req = 1'b0; // Alarm output request
  logic out_lvl = 1'b0; // Alarm output level
  logic [15:0] presc = 16'h0; // Sync prescaler
  logic tick = 1'b0; // Seconds step
  logic ss_match; // Match pulse
  logic irq; // Interrupt level
  logic [8:0] pv; // Pin outputs, alarm/osc in/osc out
  logic [31:0] rd; // Last read data
  logic [14:0] ss; // Subsecond pattern
  logic [14:0] msk; // Compared bits
  logic [15:0] pm; // Matching prescaler value
  int c; // Pulse count
  int fail_count = 0; // Mismatches
  int n_checks = 0; // Comparisons

  // Free running clock
  always #10 ref_clk_i = ~ref_clk_i;

  rtcss_top dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd_req),
    .avs_write_i(wr_req), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_req), .alarm_a_enable_i(alm_en),
    .init_mode_i(init_md), .osc_enable_i(osc_en), .alarm_out_req_i(out_req),
    .alarm_out_level_i(out_lvl), .sync_prescaler_i(presc), .second_tick_i(tick),
    .ss_match_o(ss_match), .irq_o(irq), .alarm_pin_out_o(pv[8]), .alarm_pin_oe_n_o(pv[7]),
    .alarm_pin_own_o(pv[6]), .osc_in_pin_out_o(pv[5]), .osc_in_pin_oe_n_o(pv[4]),
    .osc_in_pin_own_o(pv[3]), .osc_out_pin_out_o(pv[2]), .osc_out_pin_oe_n_o(pv[1]),
    .osc_out_pin_own_o(pv[0])
  );

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus access; request held until waitrequest is seen low at an edge
  // No local limit: only the watchdog ends a wait that never completes
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    adr <= a;
    wdat <= d;
    wr_req <= is_wr;
    rd_req <= ~is_wr;
    do begin
      @(posedge ref_clk_i);
    end while (wait_req !== 1'b0);
    rd = rdat;
    wr_req <= 1'b0;
    rd_req <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Count match pulses over a short window
  task automatic pulses(output int n);
    n = 0;
    repeat (5) begin
      @(posedge ref_clk_i);
      if (ss_match === 1'b1) n++;
    end
  endtask

  // Pin config plus side inputs, then compare masked pin outputs
  task automatic pin(input logic [5:0] cfg, input logic rq, input logic lv, input logic oe,
                     input logic [8:0] exp, input logic [8:0] m);
    wr(RTCSS_PINCFG_OFS, {8'h00, cfg, 18'h0});
    out_req <= rq;
    out_lvl <= lv;
    osc_en <= oe;
    repeat (3) @(posedge ref_clk_i);
    chk({23'h0, pv & m}, {23'h0, exp & m});
  endtask

  task automatic tally_and_finish;
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd_chk(RTCSS_ALRMSS_OFS, 32'h0);
    rd_chk(RTCSS_PINCFG_OFS, 32'h0);
    rd_chk(8'h60, 32'h0);
    // Pin overrides; released pins only show oe_n and ownership
    pin(6'b000000, 1'b0, 1'b0, 1'b1, 9'b010_010_010, 9'b011_011_011);
    pin(6'b111011, 1'b0, 1'b0, 1'b0, 9'b101_001_101, 9'b111_111_111);
    pin(6'b101110, 1'b0, 1'b0, 1'b0, 9'b001_101_001, 9'b111_111_111);
    pin(6'b101110, 1'b0, 1'b0, 1'b1, 9'b001_010_010, 9'b111_011_011);
    pin(6'b000001, 1'b1, 1'b1, 1'b1, 9'b101_010_010, 9'b111_011_011);
    pin(6'b000000, 1'b1, 1'b0, 1'b1, 9'b001_010_010, 9'b111_011_011);
    pin(6'b000000, 1'b1, 1'b1, 1'b1, 9'b010_010_010, 9'b110_011_011);
    // Locked: alarm register write refused
    wr(RTCSS_ALRMSS_OFS, 32'h0F00_1234);
    rd_chk(RTCSS_ALRMSS_OFS, 32'h0);
    rd_chk(RTCSS_STAT_OFS, 32'h2);
    wr(RTCSS_KEY_OFS, {24'h0, RTCSS_KEY1});
    wr(RTCSS_KEY_OFS, {24'h0, RTCSS_KEY2});
    wr(RTCSS_CLR_OFS, 32'h3);
    rd_chk(RTCSS_STAT_OFS, 32'h100);
    // Alarm enabled outside init mode: refused, then accepted in init mode
    alm_en <= 1'b1;
    wr(RTCSS_ALRMSS_OFS, 32'h0300_0123);
    rd_chk(RTCSS_ALRMSS_OFS, 32'h0);
    rd_chk(RTCSS_STAT_OFS, 32'h102);
    init_md <= 1'b1;
    wr(RTCSS_ALRMSS_OFS, 32'h0300_0123);
    rd_chk(RTCSS_ALRMSS_OFS, 32'h0300_0123);
    alm_en <= 1'b0;
    init_md <= 1'b0;
    wr(RTCSS_ALRMSS_OFS, 32'h0000_0000);
    rd_chk(RTCSS_ALRMSS_OFS, 32'h0);
    wr(RTCSS_CLR_OFS, 32'h3);
    // Mask zero: counter ignored, each second step matches
    presc <= 16'h1234;
    pulses(c);
    chk(32'(c), 32'd0);
    tick <= 1'b1;
    @(posedge ref_clk_i);
    tick <= 1'b0;
    pulses(c);
    chk(32'(c), 32'd1);
    // Each mask width: miss in top compared bit, then match with high bits inverted
    ss = 15'h2AD5;
    presc <= 16'h0;
    for (int m = 1; m <= 15; m++) begin
      msk = 15'((32'h1 << m) - 1);
      wr(RTCSS_ALRMSS_OFS, {4'h0, 4'(m), 9'h0, ss});
      pm = {1'b1, (ss & msk) | (~ss & ~msk)};
      presc <= pm ^ {1'b0, 15'(32'h1 << (m - 1))};
      pulses(c);
      chk(32'(c), 32'd0);
      presc <= pm;
      pulses(c);
      chk(32'(c), 32'd1);
    end
    // Event status, interrupt enable, mask and clear
    rd_chk(RTCSS_STAT_OFS, 32'h101);
    wr(RTCSS_IEN_OFS, 32'h1);
    rd_chk(RTCSS_IEN_OFS, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, irq}, 32'h1);
    wr(RTCSS_IEN_OFS, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, irq}, 32'h0);
    wr(RTCSS_IEN_OFS, 32'h1);
    wr(RTCSS_CLR_OFS, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, irq}, 32'h0);
    rd_chk(RTCSS_STAT_OFS, 32'h100);
    // Relock by a stray key, refused write, wrong second key stays locked
    wr(RTCSS_KEY_OFS, 32'h0);
    wr(RTCSS_ALRMSS_OFS, 32'h0000_0000);
    rd_chk(RTCSS_ALRMSS_OFS, 32'h0F00_2AD5);
    wr(RTCSS_KEY_OFS, {24'h0, RTCSS_KEY1});
    wr(RTCSS_KEY_OFS, 32'h11);
    wr(RTCSS_KEY_OFS, {24'h0, RTCSS_KEY2});
    rd_chk(RTCSS_STAT_OFS, 32'h2);
    // Second power-on reset clears the alarm register and relocks
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd_chk(RTCSS_ALRMSS_OFS, 32'h0);
    rd_chk(RTCSS_STAT_OFS, 32'h0);
    tally_and_finish;
  end
endmodule // rtcss_top_tb
`default_nettype wire
